// ===== common/nvcs_pkg.sv
// Constants and types shared by the configuration selector
package nvcs_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam real BUSY_TIME_MS = 3.6;
    localparam int unsigned BUSY_CYC =
        int'(BUSY_TIME_MS * 1000.0 * real'(CLK_MHZ));
    localparam int BUSY_W = 20;
    // ---------------------------------------------------------------
    // Register addresses and command fields
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_BYTE0 = 8'h00;
    localparam logic [7:0] REG_BYTE1 = 8'h01;
    localparam logic [7:0] REG_BYTE2 = 8'h02;
    localparam logic [7:0] REG_BYTE3 = 8'h03;
    localparam logic [7:0] REG_EXT = 8'hff;
    localparam logic [4:0] CMD_PREFIX = 5'h1f;
    localparam logic [5:0] ADDR_HI_ZERO = 6'h00;
    // Slave address upper bits: value is arbitrary
    localparam logic [4:0] SLAVE_ADDR_HI = 5'h0d;
    // ---------------------------------------------------------------
    // Data layout and defaults
    // ---------------------------------------------------------------
    localparam int DATA_W = 6;
    localparam logic [1:0] READ_PAD = 2'h0;
    localparam logic [1:0] SEQ_MAX = 2'h2;
    localparam int SIDE_BIT = 2;
    localparam logic [5:0] BYTE_RESET = 6'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ---------------------------------------------------------------
    // Enumerations
    // ---------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_CMD = 6'h04,
        ST_WDATA = 6'h08,
        ST_READ = 6'h10,
        ST_IGNORE = 6'h20
    } nvcs_state_t;
    typedef enum logic [2:0] {
        OVR_PINS = 3'h1,
        OVR_BYTE = 3'h2,
        OVR_EXT = 3'h4
    } nvcs_ovr_t;
endpackage : nvcs_pkg

// ===== common/nvcs_link_if.sv
// Byte-level link between the bit engine and the controller
`timescale 1ns/1ps
interface nvcs_link_if;
    logic start_p;
    logic stop_p;
    logic byte_p;
    logic rd_done_p;
    logic rd_nack;
    logic [7:0] rx_byte;
    logic ack_req;
    logic tx_en;
    logic [7:0] tx_byte;
    modport engine (output start_p, stop_p, byte_p, rd_done_p, rd_nack,
        rx_byte, input ack_req, tx_en, tx_byte);
    modport ctrl (input start_p, stop_p, byte_p, rd_done_p, rd_nack,
        rx_byte, output ack_req, tx_en, tx_byte);
endinterface : nvcs_link_if

// ===== design/nvcs_bit_engine.sv
// Serial bit engine: start/stop detection, byte shift and acknowledge
`timescale 1ns/1ps
module nvcs_bit_engine
    import nvcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe,
    nvcs_link_if.engine lnk
);
    typedef struct packed {
        logic scl_p;
        logic sda_p;
        logic busy;
        logic ackph;
        logic tx;
        logic drv;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic start_p;
        logic stop_p;
        logic byte_p;
        logic rd_p;
        logic nack;
    } nvcs_eng_t;
    nvcs_eng_t q_r, q_nxt;
    always_comb begin
        q_nxt = q_r;
        q_nxt.scl_p = scl_in;
        q_nxt.sda_p = sda_in;
        q_nxt.start_p = 1'b0;
        q_nxt.stop_p = 1'b0;
        q_nxt.byte_p = 1'b0;
        q_nxt.rd_p = 1'b0;
        if (scl_in && q_r.scl_p && q_r.sda_p && !sda_in) begin
            q_nxt.busy = 1'b1;
            q_nxt.cnt = 4'h0;
            q_nxt.ackph = 1'b0;
            q_nxt.tx = 1'b0;
            q_nxt.drv = 1'b0;
            q_nxt.start_p = 1'b1;
        end else if (scl_in && q_r.scl_p && !q_r.sda_p && sda_in) begin
            q_nxt.busy = 1'b0;
            q_nxt.tx = 1'b0;
            q_nxt.drv = 1'b0;
            q_nxt.stop_p = 1'b1;
        end else if (q_r.busy && scl_in && !q_r.scl_p) begin
            if (q_r.cnt < BITS_PER_BYTE) begin
                q_nxt.cnt = 4'(q_r.cnt + 4'h1);
                if (!q_r.tx) begin
                    q_nxt.sh = {q_r.sh[6:0], sda_in};
                    q_nxt.byte_p = (q_r.cnt == 4'h7);
                end
            end else if (q_r.tx) begin
                q_nxt.rd_p = 1'b1;
                q_nxt.nack = sda_in;
            end
        end else if (q_r.busy && !scl_in && q_r.scl_p) begin
            if (!q_r.ackph && q_r.cnt == BITS_PER_BYTE) begin
                // Transmitter releases so the master can answer
                q_nxt.ackph = 1'b1;
                q_nxt.drv = !q_r.tx && lnk.ack_req;
            end else if (q_r.ackph) begin
                q_nxt.ackph = 1'b0;
                q_nxt.cnt = 4'h0;
                q_nxt.tx = lnk.tx_en;
                q_nxt.sh = lnk.tx_byte;
                q_nxt.drv = lnk.tx_en && !lnk.tx_byte[7];
            end else if (q_r.tx) begin
                q_nxt.sh = {q_r.sh[6:0], 1'b0};
                q_nxt.drv = !q_r.sh[6];
            end
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
    assign sda_oe = q_r.drv;
    assign lnk.start_p = q_r.start_p;
    assign lnk.stop_p = q_r.stop_p;
    assign lnk.byte_p = q_r.byte_p;
    assign lnk.rd_done_p = q_r.rd_p;
    assign lnk.rd_nack = q_r.nack;
    assign lnk.rx_byte = q_r.sh;
endmodule : nvcs_bit_engine

// ===== design/nvcs_store.sv
// Stored configuration bytes with commit and post-write busy timer
`timescale 1ns/1ps
module nvcs_store
    import nvcs_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES = BUSY_CYC
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_p,
    input wire logic [1:0] wr_idx,
    input wire logic [1:0] wr_cnt,
    input wire logic [5:0] wr_d0,
    input wire logic [5:0] wr_d1,
    output logic [3:0][5:0] mem,
    output logic busy
);
    typedef struct packed {
        logic [3:0][5:0] mem;
        logic [BUSY_W-1:0] timer;
    } nvcs_store_t;
    nvcs_store_t q_r, q_nxt;
    always_comb begin
        q_nxt = q_r;
        if (wr_p) begin
            q_nxt.mem[wr_idx] = wr_d0;
            if (wr_cnt == SEQ_MAX) begin
                q_nxt.mem[2'(wr_idx + 2'h1)] = wr_d1;
            end
            q_nxt.timer = BUSY_CYCLES[BUSY_W-1:0];
        end else if (q_r.timer != '0) begin
            q_nxt.timer = q_r.timer - 1'b1;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q_r.mem <= {4{BYTE_RESET}};
            q_r.timer <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
    assign mem = q_r.mem;
    assign busy = (q_r.timer != '0);
endmodule : nvcs_store

// ===== design/nvcs_top.sv
// Top of the configuration selector: command control and output choice
`timescale 1ns/1ps
module nvcs_top
    import nvcs_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES = BUSY_CYC
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_pin,
    input wire logic write_guard,
    input wire logic [5:0] ext_in,
    input wire logic [1:0] sel_pin,
    output logic [5:0] cfg_out_o,
    output logic [5:0] cfg_out_oe,
    output logic side_bit_output
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        nvcs_state_t state;
        logic [7:0] cmd;
        logic [1:0] ptr;
        logic [1:0] base;
        logic [1:0] nbytes;
        logic [5:0] d0;
        logic [5:0] d1;
        logic reject;
        logic ack;
        logic tx_en;
        logic [7:0] tx_byte;
        logic wr_p;
        nvcs_ovr_t ovr;
        logic [1:0] byte_sel;
        logic [5:0] out;
        logic side;
    } nvcs_ctl_t;

    localparam nvcs_ctl_t CTL_RESET = '{
        state: ST_IDLE,
        cmd: REG_BYTE0,
        ptr: 2'h0,
        base: 2'h0,
        nbytes: 2'h0,
        d0: BYTE_RESET,
        d1: BYTE_RESET,
        reject: 1'b0,
        ack: 1'b0,
        tx_en: 1'b0,
        tx_byte: 8'h00,
        wr_p: 1'b0,
        ovr: OVR_PINS,
        byte_sel: 2'h0,
        out: BYTE_RESET,
        side: 1'b0
    };

    nvcs_ctl_t q_r, q_nxt;
    nvcs_link_if lnk ();
    logic [3:0][5:0] mem;
    logic nv_busy;
    logic pin_force;
    logic [5:0] src;

    // ---------------------------------------------------------------
    // Decoding helpers
    // ---------------------------------------------------------------
    function automatic logic is_loc(input logic [7:0] c);
        is_loc = (c[7:2] == ADDR_HI_ZERO);
    endfunction : is_loc

    function automatic logic is_mux(input logic [7:0] c);
        is_mux = (c[7:3] == CMD_PREFIX) && (c != REG_EXT);
    endfunction : is_mux

    // Read data depends on the last command stored, the pointer, the stored bytes and the external inputs
    function automatic logic [7:0] readback(
        input logic [7:0] c,
        input logic [1:0] p,
        input logic [3:0][5:0] m,
        input logic [5:0] e
    );
        if (c == REG_EXT) begin
            readback = {READ_PAD, e};
        end else if (is_loc(c)) begin
            readback = {READ_PAD, m[p]};
        end else begin
            readback = c;
        end
    endfunction : readback

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        q_nxt.wr_p = 1'b0;
        if (lnk.start_p) begin
            q_nxt.state = ST_ADDR;
            q_nxt.reject = 1'b0;
            q_nxt.nbytes = 2'h0;
            q_nxt.tx_en = 1'b0;
            q_nxt.ack = 1'b0;
        end else if (lnk.stop_p) begin
            // Guard looked at again so a late change cannot slip in
            if (q_r.nbytes != 2'h0 && !q_r.reject && !write_guard) begin
                q_nxt.wr_p = 1'b1;
            end
            q_nxt.state = ST_IDLE;
            q_nxt.reject = 1'b1; // Count stays for the store; no recommit
            q_nxt.tx_en = 1'b0;
            q_nxt.ack = 1'b0;
        end else if (lnk.byte_p) begin
            q_nxt.ack = 1'b0;
            case (q_r.state)
                ST_ADDR: begin
                    if (lnk.rx_byte[7:1] == {SLAVE_ADDR_HI, addr_pin}
                        && !nv_busy) begin
                        q_nxt.ack = 1'b1;
                        if (lnk.rx_byte[0]) begin
                            q_nxt.state = ST_READ;
                            q_nxt.tx_en = 1'b1;
                            q_nxt.tx_byte = readback(q_r.cmd, q_r.ptr,
                                mem, ext_in);
                        end else begin
                            q_nxt.state = ST_CMD;
                        end
                    end else begin
                        q_nxt.state = ST_IGNORE;
                    end
                end
                ST_CMD: begin
                    if (is_loc(lnk.rx_byte)) begin
                        q_nxt.cmd = lnk.rx_byte;
                        q_nxt.ptr = lnk.rx_byte[1:0];
                        q_nxt.base = lnk.rx_byte[1:0];
                        q_nxt.ack = 1'b1;
                        q_nxt.state = ST_WDATA;
                    end else if (lnk.rx_byte == REG_EXT) begin
                        // Input readback code also hands choice to pins
                        q_nxt.cmd = lnk.rx_byte;
                        q_nxt.ovr = OVR_PINS;
                        q_nxt.ack = 1'b1;
                        q_nxt.state = ST_IGNORE;
                    end else if (is_mux(lnk.rx_byte)) begin
                        q_nxt.cmd = lnk.rx_byte;
                        q_nxt.ack = 1'b1;
                        q_nxt.state = ST_IGNORE;
                        casez (lnk.rx_byte[2:0])
                            3'b000: begin
                                q_nxt.ovr = OVR_BYTE;
                                q_nxt.byte_sel = 2'h0;
                            end
                            3'b100: begin
                                q_nxt.ovr = OVR_BYTE;
                                q_nxt.byte_sel = 2'h1;
                            end
                            3'b0?1: begin
                                q_nxt.ovr = OVR_BYTE;
                                q_nxt.byte_sel = 2'h2;
                            end
                            3'b1?1: begin
                                q_nxt.ovr = OVR_BYTE;
                                q_nxt.byte_sel = 2'h3;
                            end
                            3'b?10: begin
                                q_nxt.ovr = OVR_EXT;
                            end
                            default: begin
                                q_nxt.ovr = OVR_PINS;
                            end
                        endcase
                    end else begin
                        q_nxt.state = ST_IGNORE;
                    end
                end
                ST_WDATA: begin
                    if (write_guard) begin
                        q_nxt.reject = 1'b1;
                        q_nxt.state = ST_IGNORE;
                    end else if (q_r.nbytes == SEQ_MAX) begin
                        q_nxt.reject = 1'b1;
                        q_nxt.state = ST_IGNORE;
                    end else begin
                        // Bits 7:6 of write data are dropped
                        if (q_r.nbytes == 2'h0) begin
                            q_nxt.d0 = lnk.rx_byte[5:0];
                        end else begin
                            q_nxt.d1 = lnk.rx_byte[5:0];
                        end
                        q_nxt.nbytes = 2'(q_r.nbytes + 2'h1);
                        q_nxt.ptr = 2'(q_r.ptr + 2'h1);
                        q_nxt.ack = 1'b1;
                    end
                end
                default: begin
                    q_nxt.ack = 1'b0;
                end
            endcase
        end else if (lnk.rd_done_p && q_r.state == ST_READ) begin
            if (is_loc(q_r.cmd)) begin
                q_nxt.ptr = 2'(q_r.ptr + 2'h1);
            end
            q_nxt.tx_byte = readback(q_r.cmd, q_nxt.ptr, mem, ext_in);
            if (lnk.rd_nack) begin
                q_nxt.tx_en = 1'b0;
                q_nxt.state = ST_IGNORE;
            end
        end

        // Output source choice, every cycle
        if (q_r.ovr == OVR_PINS || pin_force) begin
            q_nxt.out = sel_pin[0] ? ext_in : mem[q_r.byte_sel];
        end else begin
            q_nxt.out = src;
        end
        // Side bit follows only while select 0 is low
        if (!sel_pin[0]) begin
            q_nxt.side = (q_r.byte_sel == 2'h1) ? mem[1][SIDE_BIT]
                : mem[0][SIDE_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Command override source and pin override
    // ---------------------------------------------------------------
    // Select 1 only acts as override while byte 1 stays cleared
    assign pin_force = (mem[1] == BYTE_RESET) && sel_pin[1];
    assign src = (q_r.ovr == OVR_EXT) ? ext_in : mem[q_r.byte_sel];

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q_r <= CTL_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Link and pin outputs
    // ---------------------------------------------------------------
    assign lnk.ack_req = q_r.ack;
    assign lnk.tx_en = q_r.tx_en;
    assign lnk.tx_byte = q_r.tx_byte;
    assign sda_out = 1'b0;
    assign cfg_out_o = 6'h00;
    // Open drain: enable pulls the line low for a zero bit
    assign cfg_out_oe = ~q_r.out;
    assign side_bit_output = q_r.side;

    // ---------------------------------------------------------------
    // Leaf blocks
    // ---------------------------------------------------------------
    nvcs_bit_engine u_engine (
        .sys_clk(sys_clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe(sda_oe),
        .lnk(lnk)
    );

    nvcs_store #(
        .BUSY_CYCLES(BUSY_CYCLES)
    ) u_store (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_p(q_r.wr_p),
        .wr_idx(q_r.base),
        .wr_cnt(q_r.nbytes),
        .wr_d0(q_r.d0),
        .wr_d1(q_r.d1),
        .mem(mem),
        .busy(nv_busy)
    );
endmodule : nvcs_top

// ===== verification/nvcs_top_asserts.sv
// Port checker for the configuration selector
`timescale 1ns/1ps
module nvcs_top_asserts
    import nvcs_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES = BUSY_CYC
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [1:0] addr_pin,
    input wire logic write_guard,
    input wire logic [5:0] ext_in,
    input wire logic [1:0] sel_pin,
    input wire logic [5:0] cfg_out_o,
    input wire logic [5:0] cfg_out_oe,
    input wire logic side_bit_output
);
    // ---------------------------------------------------------------
    // No bus clock low since reset: defaults must still rule
    // ---------------------------------------------------------------
    logic quiet_r;
    logic quiet_nxt;
    always_comb begin
        quiet_nxt = quiet_r & scl_in;
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            quiet_r <= 1'b1;
        end else begin
            quiet_r <= quiet_nxt;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    reset_quiet_a: assert property (
        $fell(rst) |-> !sda_oe && side_bit_output == 1'b0)
        else $error("bus or side output active at reset release");
    pin_ext_a: assert property (
        quiet_r && $past(sel_pin[0]) && !$past(rst)
        |-> cfg_out_oe == ~$past(ext_in))
        else $error("outputs do not follow external inputs");
    pin_byte0_a: assert property (
        quiet_r && !$past(sel_pin[0]) && !$past(rst)
        |-> cfg_out_oe == 6'h3f)
        else $error("outputs not from default byte 0");
    side_default_a: assert property (
        quiet_r && !$past(rst) |-> side_bit_output == 1'b0)
        else $error("side bit not from default bytes");
    side_hold_a: assert property (
        sel_pin[0] |=> $stable(side_bit_output))
        else $error("side bit moved while latched");
    idle_steady_a: assert property (
        quiet_r && !$past(rst) && $stable(ext_in) && $stable(sel_pin)
        |=> $stable(cfg_out_oe))
        else $error("outputs moved with steady inputs");
    ack_span_a: assert property (
        $rose(sda_oe) |-> sda_oe [*6])
        else $error("data line pull too short");
    bit_stable_a: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data line moved while bus clock high");
    open_drain_a: assert property (
        cfg_out_o == 6'h00 && sda_out == 1'b0)
        else $error("open drain level not low");
    cover property ($rose(sda_oe));
    cover property (quiet_r && sel_pin[0]);
    cover property (sel_pin[0] && $changed(side_bit_output));
endmodule : nvcs_top_asserts

bind nvcs_top nvcs_top_asserts #(.BUSY_CYCLES(BUSY_CYCLES)) chk (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_pin(addr_pin),
    .write_guard(write_guard), .ext_in(ext_in), .sel_pin(sel_pin),
    .cfg_out_o(cfg_out_o), .cfg_out_oe(cfg_out_oe),
    .side_bit_output(side_bit_output));

// ===== verification/nvcs_master.sv
// Serial bus master model driving clock and data
`timescale 1ns/1ps
module nvcs_master (
    input wire logic sys_clk,
    output logic scl,
    output logic sda_pull,
    input wire logic sda,
    output logic res_v,
    output logic [7:0] res_d
);
    logic [7:0] sh;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        res_v = 1'b0;
        res_d = 8'h00;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hold
    task automatic note(input logic [7:0] v);
        res_d <= v;
        res_v <= 1'b1;
        hold(1);
        res_v <= 1'b0;
    endtask : note
    // Phases above the three-cycle minimum; data moves after clock low
    task automatic put_bit(input logic b, output logic s);
        sda_pull <= ~b;
        hold(4);
        scl <= 1'b1;
        hold(4);
        s = sda;
        scl <= 1'b0;
        hold(1);
    endtask : put_bit
    task automatic start();
        sda_pull <= 1'b0;
        hold(2);
        scl <= 1'b1;
        hold(4);
        sda_pull <= 1'b1;
        hold(4);
        scl <= 1'b0;
        hold(1);
    endtask : start
    // Clock left high after the frame: idle bus
    task automatic stop();
        sda_pull <= 1'b1;
        hold(2);
        scl <= 1'b1;
        hold(4);
        sda_pull <= 1'b0;
        hold(4);
    endtask : stop
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
        note({7'h00, ack});
    endtask : send
    task automatic fetch(input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            sh[i] = s;
        end
        put_bit(last, s);
        note(sh);
    endtask : fetch
endmodule : nvcs_master

// ===== verification/nvcs_top_bench.sv
// Self-checking bench for the configuration selector
`timescale 1ns/1ps
module nvcs_top_bench;
    import nvcs_pkg::*;
    localparam int unsigned BUSY = 150;
    localparam logic [7:0] CMDV [5] = '{8'hfa, 8'hfc, 8'hf9, 8'hfd, 8'hf8};
    localparam logic [2:0] SRCV [5] = '{3'h4, 3'h1, 3'h2, 3'h3, 3'h0};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic write_guard = 1'b0;
    logic [5:0] ext_in = 6'h00;
    logic [1:0] sel_pin = 2'h0;
    logic [1:0] addr_pin = 2'h0;
    logic scl, pull, res_v, sda_oe, sda_out, side, a, look = 1'b0;
    logic [7:0] res_d, lfsr = 8'h02;
    logic [7:0] b [4];
    logic [5:0] cfg_o, cfg_oe, e;
    logic [5:0] mem [4] = '{default: 6'h00};
    logic [7:0] q [$];
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    // Open drain data line with pull-up
    wire logic sda = ~(pull | sda_oe);
    always #2 sys_clk = ~sys_clk;
    nvcs_top #(.BUSY_CYCLES(BUSY)) dut (.sys_clk(sys_clk), .rst(rst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_pin(addr_pin), .write_guard(write_guard), .ext_in(ext_in),
        .sel_pin(sel_pin), .cfg_out_o(cfg_o), .cfg_out_oe(cfg_oe),
        .side_bit_output(side));
    nvcs_master mst (.sys_clk(sys_clk), .scl(scl), .sda_pull(pull),
        .sda(sda), .res_v(res_v), .res_d(res_d));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction : rnd
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_cyc
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, seen,
                want);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    // ---------------------------------------------------------------
    // Result watcher and hang guard
    // ---------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (res_v || look) begin
            chk(res_v ? res_d : {1'b0, side, ~cfg_oe}, q.pop_front());
        end
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            finish_test();
        end
    end
    // ---------------------------------------------------------------
    // Transfer helpers
    // ---------------------------------------------------------------
    task automatic tx(input logic [7:0] d, input logic ok);
        q.push_back({7'h00, ok});
        mst.send(d, a);
    endtask : tx
    task automatic go(input logic rw, input logic ok);
        mst.start();
        tx({SLAVE_ADDR_HI, addr_pin, rw}, ok);
    endtask : go
    task automatic rx(input logic [5:0] v, input logic last);
        q.push_back({2'h0, v});
        mst.fetch(last);
    endtask : rx
    task automatic fin();
        mst.stop();
        wait_cyc(BUSY + 20); // Master waits out the busy window
    endtask : fin
    task automatic wr(input logic [7:0] c, input logic [7:0] d0,
        input logic [7:0] d1, input int n);
        go(1'b0, 1'b1);
        tx(c, 1'b1);
        if (n > 0) tx(d0, 1'b1);
        if (n > 1) tx(d1, 1'b1);
    endtask : wr
    task automatic rd_all();
        go(1'b0, 1'b1);
        tx(REG_BYTE0, 1'b1);
        go(1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            rx(mem[i], i == 3);
        end
        fin();
    endtask : rd_all
    task automatic outs(input logic [5:0] v, input logic s);
        wait_cyc(3);
        q.push_back({1'b0, s, v});
        look <= 1'b1;
        wait_cyc(1);
        look <= 1'b0;
        wait_cyc(1);
    endtask : outs
    task automatic reset_dut();
        rst <= 1'b1;
        wait_cyc(4);
        rst <= 1'b0;
        wait_cyc(2);
    endtask : reset_dut
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        reset_dut();
        addr_pin <= 2'(rnd());
        e = 6'(rnd());
        ext_in <= e;
        sel_pin <= 2'h1;
        outs(e, 1'b0);
        sel_pin <= 2'h0;
        outs(6'h00, 1'b0);
        rd_all();
        $display("test defaults done");
        for (int i = 0; i < 4; i++) begin
            b[i] = rnd() | 8'hc0;
        end
        b[1] = b[1] | 8'h04;
        b[0] = b[0] & 8'hfb;
        wr(REG_BYTE0, b[0], b[1], 2);
        fin();
        wr(REG_BYTE2, b[2], b[3], 2);
        mst.stop();
        for (int i = 0; i < 4; i++) begin
            mem[i] = b[i][5:0];
        end
        go(1'b0, 1'b0);
        fin();
        rd_all();
        $display("test write and read done");
        go(1'b0, 1'b1);
        tx(REG_BYTE1, 1'b1);
        tx(8'h3f, 1'b1);
        tx(8'h3f, 1'b1);
        tx(8'h3f, 1'b0);
        fin();
        write_guard <= 1'b1;
        go(1'b0, 1'b1);
        tx(REG_BYTE2, 1'b1);
        tx(8'h3f, 1'b0);
        write_guard <= 1'b0;
        fin();
        wr(REG_BYTE3, 8'h3f, 8'h00, 1);
        write_guard <= 1'b1;
        fin();
        write_guard <= 1'b0;
        go(1'b0, 1'b1);
        tx(8'h10, 1'b0);
        fin();
        rd_all();
        $display("test refusals done");
        e = 6'(rnd());
        ext_in <= e;
        go(1'b0, 1'b1);
        tx(REG_EXT, 1'b1);
        go(1'b1, 1'b1);
        rx(e, 1'b1);
        fin();
        // Last command picks byte 0, so later pin mode reads byte 0
        for (int i = 0; i < 5; i++) begin
            go(1'b0, 1'b1);
            tx(CMDV[i], 1'b1);
            tx(8'h00, 1'b0);
            fin();
            outs(SRCV[i] == 3'h4 ? e : mem[SRCV[i][1:0]],
                mem[SRCV[i] == 3'h1][2]);
        end
        $display("test output commands done");
        go(1'b0, 1'b1);
        tx(REG_EXT, 1'b1);
        fin();
        sel_pin <= 2'h1;
        outs(e, mem[0][2]);
        wr(REG_BYTE0, {2'h3, mem[0] ^ 6'h04}, 8'h00, 1);
        mem[0] = mem[0] ^ 6'h04;
        fin();
        outs(e, ~mem[0][2]);
        sel_pin <= 2'h0;
        outs(mem[0], mem[0][2]);
        wr(REG_BYTE1, 8'hc0, 8'h00, 1);
        mem[1] = 6'h00;
        fin();
        go(1'b0, 1'b1);
        tx(CMDV[0], 1'b1);
        fin();
        sel_pin <= 2'h2;
        outs(mem[0], mem[0][2]);
        $display("test pin control done");
        reset_dut();
        outs(6'h00, 1'b0);
        $display("test second reset done");
        finish_test();
    end
endmodule : nvcs_top_bench
